// >>> core/swp_sync.v
// two flip-flop synchroniser for a group of pin inputs
module swp_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire sys_rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);

    reg [W-1:0] meta_r;

    // first stage feeds only the second stage
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_r <= {W{1'b0}};
            dout <= {W{1'b0}};
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

// >>> core/swp_word_port.v
// word port control: bit ordering, squelch, tx capture, clock division, apb regs
//
// Chosen here: the APB register port and the register offsets.
`include "swp_regs.vh"

module swp_word_port #(
    parameter WMAX = 16
) (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rx_serial_in,
    input wire rx_squelch_n,
    input wire diag_loopback_n,
    input wire tx_word_clock_in,
    input wire ref_clock_in,
    input wire [WMAX-1:0] tx_parallel_word,
    output reg [WMAX-1:0] rx_parallel_word,
    output reg rx_word_clock,
    output reg tx_serial_line,
    output reg tx_serial_clock,
    output reg tx_serial_clock_en,
    output reg tx_word_clock_out,
    output reg slice_mode_select
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // slot that the n-th serial bit of a word occupies
    function [3:0] bit_slot;
        input [3:0] n;
        input msb_first;
        input wide;
        reg [3:0] top;
        begin
            top = wide ? `SWP_LAST_WIDE : `SWP_LAST_NARROW;
            bit_slot = msb_first ? (top - n) : n;
        end
    endfunction

    function [3:0] last_bit;
        input wide;
        begin
            last_bit = wide ? `SWP_LAST_WIDE : `SWP_LAST_NARROW;
        end
    endfunction

    // bit count at which a word clock drops, for a square word clock
    function [3:0] half_bit;
        input wide;
        begin
            half_bit = wide ? `SWP_HALF_WIDE : `SWP_HALF_NARROW;
        end
    endfunction

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam [`SWP_CTRL_W-1:0] CTRL_RST = `SWP_CTRL_RESET;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    wire [WMAX+4:0] pin_s;

    swp_sync #(
        .W(WMAX + 5)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({tx_parallel_word, ref_clock_in, tx_word_clock_in, diag_loopback_n,
            rx_squelch_n, rx_serial_in}),
        .dout(pin_s)
    );

    wire rx_in_s = pin_s[0];
    wire squelch_n_s = pin_s[1];
    wire loopback_n_s = pin_s[2];
    wire txclk_s = pin_s[3];
    wire refclk_s = pin_s[4];
    wire [WMAX-1:0] txword_s = pin_s[WMAX+4:5];

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    reg [`SWP_CTRL_W-1:0] ctrl_r;
    reg [WMAX-1:0] rx_last_r;
    reg ref_ok_r;
    reg cfg_wide_r;
    wire [`SWP_ADDR_W-1:0] addr = paddr[`SWP_ADDR_W-1:0];
    wire setup = psel & ~penable;
    wire wr_take = psel & penable & pready & pwrite;
    wire addr_ok = (addr == `SWP_ADDR_CTRL) | (addr == `SWP_ADDR_STATUS) |
        (addr == `SWP_ADDR_RX_WORD);
    wire squelch_on = ~squelch_n_s & loopback_n_s;
    reg [31:0] rd_nxt;

    always @*
    begin
        rd_nxt = 32'h0000_0000;
        case (addr)
            `SWP_ADDR_CTRL:
            begin
                rd_nxt[`SWP_CTRL_W-1:0] = ctrl_r;
            end
            `SWP_ADDR_STATUS:
            begin
                rd_nxt[`SWP_STAT_SQUELCH] = squelch_on;
                rd_nxt[`SWP_STAT_LOOPBACK] = ~loopback_n_s;
                rd_nxt[`SWP_STAT_REF_OK] = ref_ok_r;
                rd_nxt[`SWP_STAT_WIDTH16] = cfg_wide_r;
            end
            `SWP_ADDR_RX_WORD:
            begin
                rd_nxt[WMAX-1:0] = rx_last_r;
            end
            default:
            begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // no wait state: answer computed in setup, ready in access phase
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl_r <= CTRL_RST;
        end
        else
        begin
            pready <= setup;
            if (setup)
            begin
                pslverr <= ~addr_ok;
                prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            end
            else if (pready)
            begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
            if (wr_take && addr == `SWP_ADDR_CTRL)
                ctrl_r <= pwdata[`SWP_CTRL_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // serial bit clock and word counter
    // ----------------------------------------------------------------
    // the serial bit clock is clk/2; one bit per two cycles
    reg ser_ph_r;
    reg [3:0] bit_cnt_r;
    reg cfg_rx_order_r;
    reg cfg_tx_order_r;
    reg cfg_reference_source_select_r;
    reg cfg_reference_rate_select_r;
    wire bit_tick = ser_ph_r;
    wire word_end = bit_tick && (bit_cnt_r == last_bit(cfg_wide_r));
    wire [3:0] half_word = half_bit(cfg_wide_r);

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ser_ph_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            cfg_wide_r <= CTRL_RST[`SWP_CTRL_WIDTH16];
            cfg_rx_order_r <= 1'b0;
            cfg_tx_order_r <= 1'b0;
            cfg_reference_source_select_r <= 1'b0;
            cfg_reference_rate_select_r <= 1'b0;
            slice_mode_select <= 1'b0;
            tx_serial_clock <= 1'b0;
            tx_serial_clock_en <= 1'b0;
            tx_word_clock_out <= 1'b0;
        end
        else
        begin
            ser_ph_r <= ~ser_ph_r;
            if (bit_tick)
                bit_cnt_r <= word_end ? 4'h0 : bit_cnt_r + 4'h1;
            // config other than the clock disable is only picked up between words, so no word is split
            if (word_end)
            begin
                cfg_wide_r <= ctrl_r[`SWP_CTRL_WIDTH16];
                cfg_rx_order_r <= ctrl_r[`SWP_CTRL_RX_ORDER];
                cfg_tx_order_r <= ctrl_r[`SWP_CTRL_TX_ORDER];
                cfg_reference_source_select_r <= ctrl_r[`SWP_CTRL_REFERENCE_SOURCE_SELECT];
                cfg_reference_rate_select_r <= ctrl_r[`SWP_CTRL_REFERENCE_RATE_SELECT];
                slice_mode_select <= ctrl_r[`SWP_CTRL_SLICE];
            end
            tx_serial_clock_en <= ~ctrl_r[`SWP_CTRL_CLKDIS];
            tx_serial_clock <= ~ctrl_r[`SWP_CTRL_CLKDIS] & ~ser_ph_r;
            // high for the first half of each word
            if (bit_tick)
                tx_word_clock_out <= word_end ? 1'b1 : ((bit_cnt_r + 4'h1) < half_word);
        end
    end

    // ----------------------------------------------------------------
    // transmit capture and serializer
    // ----------------------------------------------------------------
    reg txclk_d_r;
    reg [WMAX-1:0] tx_hold_r;
    reg [WMAX-1:0] tx_shift_r;
    wire txclk_rise = txclk_s & ~txclk_d_r;
    // loopback takes the bit here, not from the line flop, so words stay aligned
    wire tx_bit_now = tx_shift_r[bit_slot(bit_cnt_r, cfg_tx_order_r, cfg_wide_r)];

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            txclk_d_r <= 1'b0;
            tx_hold_r <= {WMAX{1'b0}};
            tx_shift_r <= {WMAX{1'b0}};
            tx_serial_line <= 1'b0;
        end
        else
        begin
            txclk_d_r <= txclk_s;
            if (txclk_rise)
                tx_hold_r <= txword_s;
            if (bit_tick)
                tx_serial_line <= tx_bit_now;
            if (word_end)
                tx_shift_r <= tx_hold_r;
        end
    end

    // ----------------------------------------------------------------
    // receive deserializer
    // ----------------------------------------------------------------
    // loopback feeds the serializer output back into the receiver
    wire rx_bit = loopback_n_s ? rx_in_s : tx_bit_now;
    reg [WMAX-1:0] rx_acc_r;
    reg [WMAX-1:0] rx_done;
    integer i;

    always @*
    begin
        rx_done = rx_acc_r;
        for (i = 0; i < WMAX; i = i + 1)
        begin
            if (i[3:0] == bit_slot(bit_cnt_r, cfg_rx_order_r, cfg_wide_r))
                rx_done[i] = rx_bit;
        end
        if (!cfg_wide_r)
            rx_done[WMAX-1:`SWP_WORD_NARROW] = {(WMAX-`SWP_WORD_NARROW){1'b0}};
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_acc_r <= {WMAX{1'b0}};
            rx_last_r <= {WMAX{1'b0}};
            rx_parallel_word <= {WMAX{1'b0}};
            rx_word_clock <= 1'b0;
        end
        else
        begin
            if (bit_tick)
                rx_acc_r <= word_end ? {WMAX{1'b0}} : rx_done;
            if (word_end)
                rx_last_r <= rx_done;
            // squelch is a level: it clears the word at once, not only at a boundary
            if (squelch_on)
                rx_parallel_word <= {WMAX{1'b0}};
            else if (word_end)
                rx_parallel_word <= rx_done;
            if (word_end)
                rx_word_clock <= 1'b1;
            else if (bit_tick && (bit_cnt_r + 4'h1) == half_word)
                rx_word_clock <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // reference ratio monitor
    // ----------------------------------------------------------------
    // counts serial clock periods per reference period; no pll modelled here
    reg ref_d_r;
    reg [6:0] ref_cnt_r;
    wire ref_sel = cfg_reference_source_select_r ? refclk_s : txclk_s;
    wire ref_rise = ref_sel & ~ref_d_r;
    wire [6:0] ref_mult = cfg_reference_rate_select_r ? `SWP_REF_MULT_HI : `SWP_REF_MULT_LO;
    // the tick on the rise edge counts too, else a rise on a tick loses one
    wire [6:0] ref_cnt_inc = ref_cnt_r + {6'h00, bit_tick};

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ref_d_r <= 1'b0;
            ref_cnt_r <= 7'h00;
            ref_ok_r <= 1'b0;
        end
        else
        begin
            ref_d_r <= ref_sel;
            if (ref_rise)
            begin
                ref_ok_r <= (ref_cnt_inc == ref_mult);
                ref_cnt_r <= 7'h00;
            end
            else
            begin
                if (bit_tick && ref_cnt_r != `SWP_REF_CNT_MAX)
                    ref_cnt_r <= ref_cnt_inc;
                // a stopped reference must not leave a stale ok behind
                if (ref_cnt_r == `SWP_REF_CNT_MAX)
                    ref_ok_r <= 1'b0;
            end
        end
    end

endmodule

// >>> shared/swp_regs.vh
// register map, field positions, reset values and counts of the word port control
`ifndef SWP_REGS_VH
`define SWP_REGS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SWP_ADDR_CTRL 12'h000
`define SWP_ADDR_STATUS 12'h004
`define SWP_ADDR_RX_WORD 12'h008
`define SWP_ADDR_W 12

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define SWP_CTRL_RX_ORDER 0
`define SWP_CTRL_WIDTH16 1
`define SWP_CTRL_SLICE 2
`define SWP_CTRL_REFERENCE_SOURCE_SELECT 3
`define SWP_CTRL_REFERENCE_RATE_SELECT 4
`define SWP_CTRL_CLKDIS 5
`define SWP_CTRL_TX_ORDER 6
`define SWP_CTRL_W 7
`define SWP_CTRL_RESET 7'h02

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define SWP_STAT_SQUELCH 0
`define SWP_STAT_LOOPBACK 1
`define SWP_STAT_REF_OK 2
`define SWP_STAT_WIDTH16 3

// ----------------------------------------------------------------
// word sizes and reference ratios
// ----------------------------------------------------------------
`define SWP_WORD_WIDE 16
`define SWP_WORD_NARROW 4
`define SWP_REF_MULT_LO 7'h10
`define SWP_REF_MULT_HI 7'h20
`define SWP_REF_CNT_MAX 7'h7f
`define SWP_LAST_WIDE 4'hf
`define SWP_LAST_NARROW 4'h3
`define SWP_HALF_WIDE 4'h8
`define SWP_HALF_NARROW 4'h2

`endif

// >>> verif/swp_framer_model.sv
// system framer model: words clocked by the echoed word clock, toggling serial line, counter reference
module swp_framer_model (
    input wire clk,
    input wire tx_word_clock_out,
    input wire [15:0] next_word,
    output logic tx_word_clock_in,
    output logic [15:0] tx_parallel_word,
    output logic rx_serial_in,
    output wire ref_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ref_cnt = 5'h00;
    initial
    begin
        tx_word_clock_in = 1'b0;
        tx_parallel_word = 16'h0000;
        rx_serial_in = 1'b0;
    end
    // word changes at the falling half, so it is stable around the rise
    always @(posedge clk)
    begin
        tx_word_clock_in <= tx_word_clock_out;
        if (tx_word_clock_in && !tx_word_clock_out)
            tx_parallel_word <= next_word;
        rx_serial_in <= !rx_serial_in;
        ref_cnt <= ref_cnt + 5'h01;
    end
    assign ref_clock_in = ref_cnt[4];
endmodule

// >>> verif/swp_word_port_assertions.sv
// assertions on the word port pins and apb handshake
module swp_word_port_assertions #(
    parameter WMAX = 16
) (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire rx_squelch_n,
    input wire diag_loopback_n,
    input wire [WMAX-1:0] rx_parallel_word,
    input wire rx_word_clock,
    input wire tx_serial_clock,
    input wire tx_serial_clock_en,
    input wire tx_word_clock_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ----
    // squelch held long enough to pass the pin synchronisers
    // ----
    sequence s_squelched;
        (!rx_squelch_n && diag_loopback_n) [*5];
    endsequence
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_read_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_squelch_zero: assert property (s_squelched |-> rx_parallel_word == '0)
        else $error("receive word not squelched");
    // pin changes excluded: squelch may zero the word between boundaries
    a_word_on_edge: assert property ($changed(rx_parallel_word)
        && rx_squelch_n == $past(rx_squelch_n, 4)
        && diag_loopback_n == $past(diag_loopback_n, 4) |-> $rose(rx_word_clock))
        else $error("receive word changed off the word clock");
    a_rx_clock_half: assert property ($rose(rx_word_clock) |-> rx_word_clock [*4])
        else $error("receive word clock high too short");
    a_word_out_high: assert property ($rose(tx_word_clock_out) |-> tx_word_clock_out [*4])
        else $error("word clock out high too short");
    a_word_out_low: assert property ($fell(tx_word_clock_out) |-> !tx_word_clock_out [*4])
        else $error("word clock out low too short");
    a_driver_off: assert property (!tx_serial_clock_en |-> !tx_serial_clock)
        else $error("serial clock driven while disabled");
    a_serial_runs: assert property (tx_serial_clock_en [*3]
        |-> tx_serial_clock != $past(tx_serial_clock))
        else $error("serial clock not toggling");
endmodule

bind swp_word_port swp_word_port_assertions #(.WMAX(WMAX)) i_swp_word_port_assertions (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rx_squelch_n(rx_squelch_n),
    .diag_loopback_n(diag_loopback_n),
    .rx_parallel_word(rx_parallel_word),
    .rx_word_clock(rx_word_clock),
    .tx_serial_clock(tx_serial_clock),
    .tx_serial_clock_en(tx_serial_clock_en),
    .tx_word_clock_out(tx_word_clock_out)
);

// >>> verif/tb_top.sv
// self-checking bench for the word port control
`include "swp_regs.vh"
`define chk(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic rx_squelch_n, diag_loopback_n, rx_serial_in, tx_word_clock_in, ref_clock_in;
    logic [15:0] tx_parallel_word, rx_parallel_word, next_word, line_w;
    logic rx_word_clock, tx_serial_line, tx_serial_clock, tx_serial_clock_en;
    logic tx_word_clock_out, slice_mode_select;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    time t0;
    logic [31:0] ctl [4] = '{32'h02, 32'h03, 32'h00, 32'h01};
    logic [15:0] exp_w [4] = '{16'hA5CB, 16'hD3A5, 16'h000B, 16'h000D};
    int per [4] = '{32, 32, 8, 8};
    swp_word_port i_swp_word_port (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_serial_in(rx_serial_in),
        .rx_squelch_n(rx_squelch_n), .diag_loopback_n(diag_loopback_n),
        .tx_word_clock_in(tx_word_clock_in), .ref_clock_in(ref_clock_in),
        .tx_parallel_word(tx_parallel_word), .rx_parallel_word(rx_parallel_word),
        .rx_word_clock(rx_word_clock), .tx_serial_line(tx_serial_line),
        .tx_serial_clock(tx_serial_clock), .tx_serial_clock_en(tx_serial_clock_en),
        .tx_word_clock_out(tx_word_clock_out), .slice_mode_select(slice_mode_select));
    swp_framer_model i_swp_framer_model (.clk(clk), .tx_word_clock_out(tx_word_clock_out),
        .next_word(next_word), .tx_word_clock_in(tx_word_clock_in),
        .tx_parallel_word(tx_parallel_word), .rx_serial_in(rx_serial_in),
        .ref_clock_in(ref_clock_in));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard, far above the roughly 1400 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {20'h0_0000, a};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task settle_words(input logic [31:0] c);
        apb(1'b1, `SWP_ADDR_CTRL, c);
        repeat (4) @(posedge rx_word_clock);
        @(posedge clk);
    endtask
    // next word off the serial line, each bit taken one cycle after its tick
    task grab_line;
        @(posedge tx_word_clock_out);
        @(posedge clk);
        for (int k = 0; k < 16; k++)
        begin
            repeat (2) @(posedge clk);
            line_w[k] = tx_serial_line;
        end
    endtask
    initial
    begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 67'h0};
        {rx_squelch_n, diag_loopback_n, next_word} = {2'b11, 16'hA5CB};
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, `SWP_ADDR_CTRL, 32'h0000_0000);
        `chk(rd, 32'h0000_0002)
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `chk({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
        diag_loopback_n <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            settle_words(ctl[i]);
            `chk(rx_parallel_word, exp_w[i])
            @(posedge tx_word_clock_out);
            t0 = $time;
            @(posedge tx_word_clock_out);
            `chk(int'(($time - t0) / 20), per[i])
        end
        settle_words(32'h0000_0042);
        `chk(rx_parallel_word, 16'hD3A5)
        apb(1'b0, `SWP_ADDR_CTRL, 32'h0000_0000);
        `chk(rd, 32'h0000_0042)
        grab_line();
        `chk(line_w, 16'hD3A5)
        rx_squelch_n <= 1'b0;
        settle_words(32'h0000_0002);
        `chk(rx_parallel_word, 16'hA5CB)
        grab_line();
        `chk(line_w, 16'hA5CB)
        apb(1'b0, `SWP_ADDR_STATUS, 32'h0000_0000);
        `chk(rd[2], 1'b1)
        settle_words(32'h0000_0012);
        apb(1'b0, `SWP_ADDR_STATUS, 32'h0000_0000);
        `chk(rd[2], 1'b0)
        settle_words(32'h0000_000A);
        apb(1'b0, `SWP_ADDR_STATUS, 32'h0000_0000);
        `chk(rd[2], 1'b1)
        diag_loopback_n <= 1'b1;
        settle_words(32'h0000_0026);
        `chk(rx_parallel_word, 16'h0000)
        apb(1'b0, `SWP_ADDR_STATUS, 32'h0000_0000);
        `chk(rd, 32'h0000_000D)
        `chk({slice_mode_select, tx_serial_clock_en}, 2'b10)
        settle_words(32'h0000_0002);
        `chk({slice_mode_select, tx_serial_clock_en}, 2'b01)
        give_verdict();
    end
endmodule
